// ### logic/ext_bus_pkg.sv
// Package with constants for the external bus interface
package ext_bus_pkg;
  localparam int          ADDR_WIDTH      = 23;
  localparam int          DATA_WIDTH      = 16;
  localparam int          WAIT_WIDTH      = 3;
  // Fewest software wait states that enable READY detection
  localparam logic [2:0]  READY_MIN_WAITS = 3'h2;
  // Synchroniser depth for pin inputs
  localparam int          SYNC_STAGES     = 3;
  localparam logic [2:0]  WAIT_RESET      = 3'h0;
  typedef enum logic [1:0] {SPACE_DATA, SPACE_PROG, SPACE_IO} space_type;
  typedef enum {ST_IDLE, ST_WAIT, ST_READY, ST_HOLD} bus_state_type;
endpackage

// ### logic/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Pin and filtered level
  input  wire logic pin,
  output logic      level
);
  logic [2:0] stage;

  // First stage only feeds the second, a change counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage <= {3{RESET_LEVEL}};
      level <= RESET_LEVEL;
    end
    else
    begin
      stage <= {stage[1:0], pin};
      if (stage[1] == stage[2])
        level <= stage[2];
    end
  end
endmodule
`default_nettype wire

// ### logic/dsp_external_bus_interface.sv
// External bus control: selects, strobes, wait states, hold and output disable
// What this block does
// RULE1: Space selects high except during own access, low with valid address.
// RULE2: Space selects float while in hold.
// RULE3: Memory strobe low only during data or program memory access.
// RULE4: I/O strobe low only during I/O access.
// RULE5: Both strobes float while in hold.
// RULE6: Direction rests high for read, low only during writes.
// RULE7: Direction floats in hold or while output disable low.
// RULE8: READY low stretches access; wait one cycle and sample again.
// RULE9: READY honoured only with two or more software wait states.
// RULE10: READY not sampled before software wait states finish.
// RULE11: External master requests hold; bus lines float once acknowledged.
// RULE12: Hold acknowledge asserted exactly while in hold with lines released.
// RULE13: Microstate complete low during last wait state when two or more.
// RULE14: Tying microstate complete to READY yields one extra external wait; here the READY filter drops that one-cycle low, so no wait is added.
// RULE15: Output disable low floats acknowledge, selects, strobes, microstate output.
// RULE16: Address bus floats in hold or while output disable low.
// RULE17: Data bus floats unless writing, and in reset or hold request.
// RULE18: Wait state count comes from a software configuration input.
// RULE19: Hold granted only between accesses, never mid strobe.
`timescale 1ns/1ps
`default_nettype none
module dsp_external_bus_interface #(
  parameter int ADDR_WIDTH = ext_bus_pkg::ADDR_WIDTH,
  parameter int DATA_WIDTH = ext_bus_pkg::DATA_WIDTH,
  parameter int WAIT_WIDTH = ext_bus_pkg::WAIT_WIDTH
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  // CPU side access request
  input  wire logic                  cpu_req,
  input  wire logic [1:0]            cpu_space,
  input  wire logic                  cpu_write,
  input  wire logic [ADDR_WIDTH-1:0] cpu_addr,
  input  wire logic [DATA_WIDTH-1:0] cpu_wdata,
  input  wire logic [WAIT_WIDTH-1:0] wait_states,
  output logic                       cpu_ack,
  output logic [DATA_WIDTH-1:0]      cpu_rdata,
  // External pins, inputs
  input  wire logic                  ready_pin,
  input  wire logic                  hold_request_n,
  input  wire logic                  output_disable_n,
  input  wire logic [DATA_WIDTH-1:0] data_in,
  // Address and data with active-low enables
  output logic [ADDR_WIDTH-1:0]      addr_out,
  output logic                       addr_oe_n,
  output logic [DATA_WIDTH-1:0]      data_out,
  output logic                       data_oe_n,
  // Control outputs, each with an active-low enable
  output logic                       data_space_select_n,
  output logic                       program_space_select_n,
  output logic                       io_space_select_n,
  output logic                       select_oe_n,
  output logic                       memory_strobe_n,
  output logic                       io_strobe_n,
  output logic                       strobe_oe_n,
  output logic                       read_write,
  output logic                       read_write_oe_n,
  output logic                       hold_acknowledge_n,
  output logic                       hold_acknowledge_oe_n,
  output logic                       microstate_complete_n,
  output logic                       microstate_complete_oe_n
);
  ext_bus_pkg::bus_state_type state;
  logic [WAIT_WIDTH-1:0]      wait_count;
  logic [WAIT_WIDTH-1:0]      wait_total;
  logic [1:0]                 space;
  logic                       writing;
  logic                       ready_level;
  logic                       hold_level;
  logic                       enable_level;
  logic                       in_access;
  logic                       ready_checked;
  logic                       finishing;

  // READY, hold request and output disable pins pass the agreement synchroniser
  pin_sync #(.RESET_LEVEL(1'b1)) u_ready_sync
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     (ready_pin),
    .level   (ready_level)
  );
  pin_sync #(.RESET_LEVEL(1'b1)) u_hold_sync
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     (hold_request_n),
    .level   (hold_level)
  );
  pin_sync #(.RESET_LEVEL(1'b1)) u_off_sync
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     (output_disable_n),
    .level   (enable_level)
  );

  // READY only counts with enough waits programmed
  assign ready_checked = (wait_total >= WAIT_WIDTH'(ext_bus_pkg::READY_MIN_WAITS)); // see RULE9
  assign in_access     = (state == ext_bus_pkg::ST_WAIT) || (state == ext_bus_pkg::ST_READY);

  // Access sequencer; hold is taken only from idle so no strobe is cut short
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state      <= ext_bus_pkg::ST_IDLE;
      wait_count <= WAIT_WIDTH'(ext_bus_pkg::WAIT_RESET);
      wait_total <= WAIT_WIDTH'(ext_bus_pkg::WAIT_RESET);
      space      <= 2'h0;
      writing    <= 1'b0;
      addr_out   <= '0;
      data_out   <= '0;
      cpu_rdata  <= '0;
      cpu_ack    <= 1'b0;
      finishing  <= 1'b0;
    end
    else
    begin
      // Read data is taken one edge after the sequencer ends, while the
      // registered strobe still stands; otherwise a zero-wait read would
      // sample the bus before the device was ever selected
      finishing <= 1'b0;
      cpu_ack   <= finishing;
      if (finishing)
        cpu_rdata <= data_in;
      unique case (state)
        ext_bus_pkg::ST_IDLE:
        begin
          if (!hold_level)
            state <= ext_bus_pkg::ST_HOLD; // see RULE19
          else if (cpu_req)
          begin
            state      <= ext_bus_pkg::ST_WAIT;
            wait_count <= wait_states; // see RULE18
            wait_total <= wait_states;
            space      <= cpu_space;
            writing    <= cpu_write;
            addr_out   <= cpu_addr;
            data_out   <= cpu_wdata;
          end
        end
        ext_bus_pkg::ST_WAIT:
        begin
          // Software waits run out before READY is looked at
          if (wait_count != '0)
            wait_count <= wait_count - WAIT_WIDTH'(1); // see RULE10
          else if (ready_checked)
            state <= ext_bus_pkg::ST_READY;
          else
          begin
            state     <= ext_bus_pkg::ST_IDLE;
            finishing <= 1'b1;
          end
        end
        ext_bus_pkg::ST_READY:
        begin
          // Low READY costs one cycle, then it is sampled again
          if (ready_level) // see RULE8
          begin
            state     <= ext_bus_pkg::ST_IDLE;
            finishing <= 1'b1;
          end
        end
        ext_bus_pkg::ST_HOLD:
        begin
          if (hold_level)
            state <= ext_bus_pkg::ST_IDLE; // see RULE11
        end
      endcase
    end
  end

  // Control levels, registered so pins are glitch free
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      data_space_select_n    <= 1'b1;
      program_space_select_n <= 1'b1;
      io_space_select_n      <= 1'b1;
      memory_strobe_n        <= 1'b1;
      io_strobe_n            <= 1'b1;
      read_write             <= 1'b1;
      hold_acknowledge_n     <= 1'b1;
      microstate_complete_n  <= 1'b1;
    end
    else
    begin
      data_space_select_n    <= !(in_access && space == 2'(ext_bus_pkg::SPACE_DATA)); // see RULE1
      program_space_select_n <= !(in_access && space == 2'(ext_bus_pkg::SPACE_PROG)); // see RULE1
      io_space_select_n      <= !(in_access && space == 2'(ext_bus_pkg::SPACE_IO)); // see RULE1
      memory_strobe_n        <= !(in_access && space != 2'(ext_bus_pkg::SPACE_IO)); // see RULE3
      io_strobe_n            <= !(in_access && space == 2'(ext_bus_pkg::SPACE_IO)); // see RULE4
      read_write             <= !(in_access && writing); // see RULE6
      hold_acknowledge_n     <= !(state == ext_bus_pkg::ST_HOLD); // see RULE12
      // Low while the last software wait runs; one cycle only, so a tie to READY is dropped by the filter and adds no wait
      microstate_complete_n  <= !(state == ext_bus_pkg::ST_WAIT && ready_checked
                                  && wait_count == WAIT_WIDTH'(1)); // see RULE13
    end
  end

  // Output enables, registered; output disable releases every pin, hold all but acknowledge and microstate complete
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      addr_oe_n                <= 1'b1;
      data_oe_n                <= 1'b1;
      select_oe_n              <= 1'b1;
      strobe_oe_n              <= 1'b1;
      read_write_oe_n          <= 1'b1;
      hold_acknowledge_oe_n    <= 1'b1;
      microstate_complete_oe_n <= 1'b1;
    end
    else
    begin
      addr_oe_n                <= !(enable_level && state != ext_bus_pkg::ST_HOLD); // see RULE16
      data_oe_n                <= !(enable_level && hold_level && in_access
                                    && writing); // see RULE17
      select_oe_n              <= !(enable_level && state != ext_bus_pkg::ST_HOLD); // see RULE2
      strobe_oe_n              <= !(enable_level && state != ext_bus_pkg::ST_HOLD); // see RULE5
      read_write_oe_n          <= !(enable_level && state != ext_bus_pkg::ST_HOLD); // see RULE7
      hold_acknowledge_oe_n    <= !enable_level; // see RULE15
      microstate_complete_oe_n <= !enable_level; // see RULE15
    end
  end
endmodule
`default_nettype wire

// ### tb/ext_bus_checker.sv
// Pin assertions for the external bus interface
`timescale 1ns/1ps
`default_nettype none
module ext_bus_checker (
  // Clock, reset and inputs
  input wire logic       sys_clk, reset_n, cpu_ack, hold_request_n, output_disable_n,
  input wire logic [2:0] wait_states,
  // Selects, strobes and status
  input wire logic       data_space_select_n, program_space_select_n, io_space_select_n,
  input wire logic       memory_strobe_n, io_strobe_n, hold_acknowledge_n, microstate_complete_n,
  // Output enables
  input wire logic       addr_oe_n, select_oe_n, strobe_oe_n, read_write_oe_n,
  input wire logic       hold_acknowledge_oe_n, microstate_complete_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Selects and strobes share one access window
  a_one_select: assert property (
    $onehot0({!data_space_select_n, !program_space_select_n, !io_space_select_n}))
    else $error("two selects low");
  a_io_select: assert property (!io_space_select_n |-> !io_strobe_n && memory_strobe_n)
    else $error("io select without io strobe");
  a_mem_select: assert property (
    !(data_space_select_n && program_space_select_n) |-> !memory_strobe_n && io_strobe_n)
    else $error("memory select without memory strobe");
  // Hold floats the bus and waits for a quiet bus
  a_hold_floats: assert property (
    !hold_acknowledge_n |-> addr_oe_n && select_oe_n && strobe_oe_n && read_write_oe_n)
    else $error("bus driven in hold");
  a_hold_quiet: assert property ($fell(hold_acknowledge_n) |-> memory_strobe_n && io_strobe_n)
    else $error("hold granted mid strobe");
  a_hold_release: assert property (hold_request_n [*8] |=> hold_acknowledge_n)
    else $error("hold kept after release");
  // Output disable, after the pin filter settles
  a_off_floats: assert property (!output_disable_n [*8] |=> select_oe_n && strobe_oe_n &&
    read_write_oe_n && hold_acknowledge_oe_n && microstate_complete_oe_n && addr_oe_n)
    else $error("output still driven while disabled");
  a_msc_pulse: assert property (
    !microstate_complete_n |-> wait_states >= 3'h2 ##1 microstate_complete_n)
    else $error("bad microstate pulse");
  cover property (!io_strobe_n);
  cover property (!hold_acknowledge_n);
  cover property (!microstate_complete_n);
endmodule
bind dsp_external_bus_interface ext_bus_checker u_chk (.sys_clk, .reset_n, .cpu_ack,
  .hold_request_n, .output_disable_n, .wait_states, .data_space_select_n,
  .program_space_select_n, .io_space_select_n, .memory_strobe_n, .io_strobe_n,
  .hold_acknowledge_n, .microstate_complete_n, .addr_oe_n, .select_oe_n, .strobe_oe_n,
  .read_write_oe_n, .hold_acknowledge_oe_n, .microstate_complete_oe_n);
`default_nettype wire

// ### tb/ext_bus_partner.sv
// Behavioural memory and I/O device on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module ext_bus_partner (
  // Clock and bus pins
  input wire logic        sys_clk, memory_strobe_n, io_strobe_n, read_write,
  input wire logic [22:0] addr_out,
  // Stall length in cycles, zero answers at once
  input wire logic [7:0]  stall,
  output logic            ready_pin,
  output logic [15:0]     data_in
);
  logic [7:0] cnt = 8'h0;
  wire logic  idle = memory_strobe_n && io_strobe_n;
  // Cycles into the current strobe, saturating
  always @(posedge sys_clk) cnt <= idle ? 8'h0 : cnt + {7'h0, cnt != 8'hff};
  // A busy device keeps READY low between strobes too, so the filtered level is low in time
  assign ready_pin = cnt >= stall;
  // Read data while selected; a released bus shows the inverse so stale data never matches
  assign data_in = (read_write && !idle) ? addr_out[15:0] ^ 16'h5a5a
                                         : ~(addr_out[15:0] ^ 16'h5a5a);
endmodule
`default_nettype wire

// ### tb/dsp_external_bus_interface_tb.sv
// Testbench for the external bus interface
`timescale 1ns/1ps
`default_nettype none
module dsp_external_bus_interface_tb;
  logic        sys_clk = 1'b0, reset_n = 1'b0, cpu_req = 1'b0, cpu_write = 1'b0;
  logic        hold_request_n = 1'b1, output_disable_n = 1'b1, ready_pin, cpu_ack;
  logic        addr_oe_n, data_oe_n, data_space_select_n, program_space_select_n;
  logic        io_space_select_n, select_oe_n, memory_strobe_n, io_strobe_n, strobe_oe_n;
  logic        read_write, read_write_oe_n, hold_acknowledge_n, hold_acknowledge_oe_n;
  logic        microstate_complete_n, microstate_complete_oe_n;
  logic [1:0]  cpu_space = 2'h0;
  logic [2:0]  wait_states = 3'h0;
  logic [7:0]  stall = 8'h0;
  logic [22:0] cpu_addr = 23'h0, addr_out;
  logic [15:0] cpu_wdata = 16'h0, cpu_rdata, data_in, data_out;
  int          err_count = 0, samples_checked = 0;
  dsp_external_bus_interface dut (.sys_clk, .reset_n, .cpu_req, .cpu_space, .cpu_write,
    .cpu_addr, .cpu_wdata, .wait_states, .cpu_ack, .cpu_rdata, .ready_pin, .hold_request_n,
    .output_disable_n, .data_in, .addr_out, .addr_oe_n, .data_out, .data_oe_n,
    .data_space_select_n, .program_space_select_n, .io_space_select_n, .select_oe_n,
    .memory_strobe_n, .io_strobe_n, .strobe_oe_n, .read_write, .read_write_oe_n,
    .hold_acknowledge_n, .hold_acknowledge_oe_n, .microstate_complete_n,
    .microstate_complete_oe_n);
  ext_bus_partner u_dev (.sys_clk, .memory_strobe_n, .io_strobe_n, .read_write, .addr_out,
    .stall, .ready_pin, .data_in);
  // Free running 100 MHz clock
  initial forever #5 sys_clk = ~sys_clk;
  task end_sim;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access, recording which pins went low while it ran
  task acc(input logic [1:0] sp, input logic wr, input logic [2:0] w, input logic [7:0] st);
    int n;
    logic [7:0] seen;
    logic [15:0] dw;
    n = 0;
    seen = 8'h0;
    dw = 16'h0;
    {cpu_space, cpu_write, wait_states, stall, cpu_req} <= {sp, wr, w, st, 1'b1};
    cpu_addr <= {21'h0d15, sp};
    cpu_wdata <= {14'h2b3c, sp};
    @(posedge sys_clk) cpu_req <= 1'b0;
    while (cpu_ack !== 1'b1 && n < 60)
    begin
      @(posedge sys_clk) #1 n++;
      seen |= ~{data_space_select_n, program_space_select_n, io_space_select_n,
        memory_strobe_n, io_strobe_n, read_write, data_oe_n, microstate_complete_n};
      if (data_oe_n === 1'b0) dw = data_out;
    end
    chk(seen, {sp == 0, sp == 1, sp == 2, sp != 2, sp == 2, wr, wr, w >= 2});
    if (w >= 2 && st != 0) chk(n > w + 5, 1'b1);
    else chk(n, w + (w >= 2 ? 3 : 2));
    if (wr) chk(dw, cpu_wdata);
    else chk(cpu_rdata, cpu_addr[15:0] ^ 16'h5a5a);
    @(posedge sys_clk);
  endtask
  // Hold asked mid access, request refused while held
  task hold_scn;
    int n;
    logic a;
    n = 0;
    a = 1'b0;
    {cpu_space, cpu_write, wait_states, stall, cpu_req} <= {2'h0, 1'h0, 3'h7, 8'h0, 1'b1};
    @(posedge sys_clk) cpu_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
    hold_request_n <= 1'b0;
    while (hold_acknowledge_n !== 1'b0 && n < 40)
    begin
      @(posedge sys_clk) #1 n++;
      a |= cpu_ack;
    end
    chk(a, 1'b1);
    chk({addr_oe_n, data_oe_n, select_oe_n, strobe_oe_n, read_write_oe_n}, 5'h1f);
    a = 1'b0;
    @(posedge sys_clk) cpu_req <= 1'b1;
    repeat (10) @(posedge sys_clk) #1 a |= cpu_ack;
    @(posedge sys_clk) {cpu_req, hold_request_n} <= 2'h1;
    n = 0;
    while (hold_acknowledge_n !== 1'b1 && n < 40) @(posedge sys_clk) #1 n++;
    chk({a, hold_acknowledge_n, read_write}, 3'h3);
    @(posedge sys_clk);
  endtask
  // Output disable floats every control output; on restore only selects, strobes and acknowledge are checked
  task off_scn;
    output_disable_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 chk({select_oe_n, strobe_oe_n, read_write_oe_n, hold_acknowledge_oe_n,
      microstate_complete_oe_n, addr_oe_n}, 6'h3f);
    @(posedge sys_clk) output_disable_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 chk({select_oe_n, strobe_oe_n, hold_acknowledge_oe_n}, 3'h0);
  endtask
  // Main sequence after the reset pulse
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    acc(2'h0, 1'h0, 3'h0, 8'h0);
    acc(2'h1, 1'h1, 3'h1, 8'hc);
    acc(2'h2, 1'h0, 3'h2, 8'h0);
    acc(2'h0, 1'h1, 3'h3, 8'hc);
    acc(2'h2, 1'h1, 3'h2, 8'hc);
    acc(2'h1, 1'h0, 3'h7, 8'h0);
    hold_scn;
    off_scn;
    end_sim;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #20000;
    err_count++;
    end_sim;
  end
endmodule
`default_nettype wire
